// [afe_device.sv]
// Device end: register file behind the host serial link
`timescale 1ns/10ps
module afe_device
   import link_pkg::*;
(
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              rst,
   // Link
   link_if.device                 link,
   // Datapath side
   input  wire logic [WORD_W-1:0] adc_result_sample,
   input  wire logic              adc_result_load,
   input  wire logic [WORD_W-1:0] resampler_out_sample,
   input  wire logic              resampler_out_load,
   output logic [WORD_W-1:0]      converter_out_sample,
   output logic [WORD_W-1:0]      resampler_in_sample,
   input  wire logic              converter_consume,
   input  wire logic              resampler_consume,
   output logic [WORD_W-1:0]      converter_feed,
   output logic [WORD_W-1:0]      resampler_feed,
   output logic [WORD_W-1:0]      ctrl_out [NUM_CTRL]
);
   typedef enum {TX_IDLE, TX_ADDR, TX_WAIT, TX_DATA} tx_state_t;

   logic [2:0] clk_sync_reg;
   logic [1:0] din_sync_reg;
   logic [1:0] fs_sync_reg;
   logic       fall_edge;
   logic       rise_edge;
   logic [WORD_W-1:0] rx_word;
   logic              rx_valid;
   logic              tx_busy;
   logic              tx_start;
   logic [WORD_W-1:0] tx_word;
   logic              have_addr_reg;
   logic [WORD_W-1:0] addr_word_reg;
   logic [ADDR_W-1:0] req_addr_reg;
   logic              read_pend_reg;
   logic              adc_pend_reg;
   logic              res_pend_reg;
   tx_state_t         tx_state_reg;
   logic [ADDR_W-1:0] src_addr_reg;
   logic [WORD_W-1:0] adc_result_reg;
   logic [WORD_W-1:0] resampler_out_reg;
   logic [WORD_W-1:0] ctrl_reg [NUM_CTRL];

   // ---------------------------------------------
   // Pin sampling and link clock edges
   // ---------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         clk_sync_reg <= '0;
         din_sync_reg <= '0;
         fs_sync_reg  <= '0;
      end else begin
         clk_sync_reg <= {clk_sync_reg[1:0], link.bit_clock};
         din_sync_reg <= {din_sync_reg[0], link.serial_in_line};
         fs_sync_reg  <= {fs_sync_reg[0], link.serial_in_frame_sync};
      end
   end
   assign fall_edge = clk_sync_reg[2] && !clk_sync_reg[1];
   assign rise_edge = !clk_sync_reg[2] && clk_sync_reg[1];

   word_shifter shifter (
      .clk       (clk),
      .rst       (rst),
      .fall_edge (fall_edge),
      .rise_edge (rise_edge),
      .rx_line   (din_sync_reg[1]),
      .rx_sync   (fs_sync_reg[1]),
      .rx_word   (rx_word),
      .rx_valid  (rx_valid),
      .tx_word   (tx_word),
      .tx_start  (tx_start),
      .tx_busy   (tx_busy),
      .tx_line   (link.serial_out_line),
      .tx_sync   (link.serial_out_frame_sync)
   );

   // ---------------------------------------------
   // Inbound pairing and register writes
   // ---------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         have_addr_reg <= 1'b0;
         addr_word_reg <= '0;
      end else if (rx_valid) begin
         have_addr_reg <= !have_addr_reg;
         if (!have_addr_reg) addr_word_reg <= rx_word;
      end
   end

   generate
      for (genvar i = 0; i < NUM_CTRL; i++) begin : g_ctrl
         always_ff @(posedge clk) begin
            if (rst) begin
               ctrl_reg[i] <= CTRL_RESET;
            end else if (rx_valid && have_addr_reg
                         && !addr_word_reg[RW_BIT]
                         && addr_word_reg[ADDR_W-1:0] == ADDR_W'(i)) begin
               ctrl_reg[i] <= rx_word;
            end
         end
         assign ctrl_out[i] = ctrl_reg[i];
      end
   endgenerate

   // Held until consumed, so host may write anywhere in the period
   always_ff @(posedge clk) begin
      if (rst) begin
         converter_out_sample <= SAMPLE_RESET;
         resampler_in_sample  <= SAMPLE_RESET;
         converter_feed       <= SAMPLE_RESET;
         resampler_feed       <= SAMPLE_RESET;
      end else begin
         if (rx_valid && have_addr_reg && !addr_word_reg[RW_BIT]) begin
            if (addr_word_reg[ADDR_W-1:0] == CONVERTER_OUT_SAMPLE_ADDR)
               converter_out_sample <= rx_word;
            if (addr_word_reg[ADDR_W-1:0] == RESAMPLER_IN_SAMPLE_ADDR)
               resampler_in_sample <= rx_word;
            // Writes to 0x08..0x1F fall through unused
         end
         if (converter_consume) converter_feed <= converter_out_sample;
         if (resampler_consume) resampler_feed <= resampler_in_sample;
      end
   end

   // ---------------------------------------------
   // Read-only sample registers and send requests
   // ---------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         adc_result_reg    <= SAMPLE_RESET;
         resampler_out_reg <= SAMPLE_RESET;
         adc_pend_reg      <= 1'b0;
         res_pend_reg      <= 1'b0;
         read_pend_reg     <= 1'b0;
         req_addr_reg      <= '0;
      end else begin
         if (adc_result_load) adc_result_reg <= adc_result_sample;
         if (resampler_out_load)
            resampler_out_reg <= resampler_out_sample;
         // New event wins over the clear of the same cycle
         if (tx_state_reg == TX_IDLE && !read_pend_reg && adc_pend_reg)
            adc_pend_reg <= 1'b0;
         else if (tx_state_reg == TX_IDLE && !read_pend_reg
                  && res_pend_reg && !adc_pend_reg)
            res_pend_reg <= 1'b0;
         if (adc_result_load) adc_pend_reg <= 1'b1;
         if (resampler_out_load) res_pend_reg <= 1'b1;
         if (tx_state_reg == TX_IDLE && read_pend_reg)
            read_pend_reg <= 1'b0;
         // Read served once the dummy word is in
         if (rx_valid && have_addr_reg && addr_word_reg[RW_BIT]) begin
            read_pend_reg <= 1'b1;
            req_addr_reg  <= addr_word_reg[ADDR_W-1:0];
         end
      end
   end

   // ---------------------------------------------
   // Outbound address/data pair sequencer
   // ---------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         tx_state_reg <= TX_IDLE;
         src_addr_reg <= '0;
      end else begin
         case (tx_state_reg)
            TX_IDLE: begin
               // Pair in progress always completes first
               if (read_pend_reg) begin
                  src_addr_reg <= req_addr_reg;
                  tx_state_reg <= TX_ADDR;
               end else if (adc_pend_reg) begin
                  src_addr_reg <= ADC_RESULT_SAMPLE_ADDR;
                  tx_state_reg <= TX_ADDR;
               end else if (res_pend_reg) begin
                  src_addr_reg <= RESAMPLER_OUT_SAMPLE_ADDR;
                  tx_state_reg <= TX_ADDR;
               end
            end
            TX_ADDR: if (!tx_busy) tx_state_reg <= TX_WAIT;
            TX_WAIT: if (!tx_busy) tx_state_reg <= TX_DATA;
            TX_DATA: tx_state_reg <= TX_IDLE;
            default: tx_state_reg <= TX_IDLE;
         endcase
      end
   end

   always_comb begin
      tx_start = (tx_state_reg == TX_ADDR || tx_state_reg == TX_WAIT)
                 && !tx_busy;
      // Address word: bits 15..5 zero, address low
      tx_word = {11'h000, src_addr_reg};
      if (tx_state_reg == TX_WAIT) begin
         case (src_addr_reg)
            ADC_RESULT_SAMPLE_ADDR:    tx_word = adc_result_reg;
            RESAMPLER_OUT_SAMPLE_ADDR: tx_word = resampler_out_reg;
            default: tx_word = (src_addr_reg < ADDR_W'(NUM_CTRL))
                               ? ctrl_reg[src_addr_reg[2:0]] : 16'h0000;
         endcase
      end
   end
endmodule : afe_device

// [dsp_host.sv]
// Host end: drives the link clock and sends and receives words
`timescale 1ns/10ps
module dsp_host
   import link_pkg::*;
(
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              rst,
   // Link
   link_if.host                   link,
   // Request: read flag, address, data (dummy for read)
   input  wire logic              req_valid,
   input  wire logic              req_read,
   input  wire logic [ADDR_W-1:0] req_addr,
   input  wire logic [WORD_W-1:0] req_data,
   output logic                   req_ready,
   // Received pairs
   output logic [ADDR_W-1:0]      rsp_addr,
   output logic [WORD_W-1:0]      rsp_data,
   output logic                   rsp_valid
);
   logic [3:0]        div_reg;
   logic              bclk_reg;
   logic              fall_edge;
   logic              rise_edge;
   logic [1:0]        dout_sync_reg;
   logic [1:0]        fsync_sync_reg;
   logic [WORD_W-1:0] rx_word;
   logic              rx_valid;
   logic              tx_busy;
   logic              tx_start;
   logic [WORD_W-1:0] tx_word;
   logic              second_reg;
   logic [WORD_W-1:0] data_hold_reg;
   logic              got_addr_reg;

   // ---------------------------------------------
   // Bit clock divider
   // ---------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         div_reg  <= '0;
         bclk_reg <= 1'b0;
      end else if (div_reg == 4'(LINK_HALF_DIV - 1)) begin
         div_reg  <= '0;
         bclk_reg <= !bclk_reg;
      end else begin
         div_reg <= div_reg + 4'h1;
      end
   end
   assign rise_edge = (div_reg == 4'(LINK_HALF_DIV - 1)) && !bclk_reg;
   assign fall_edge = (div_reg == 4'(LINK_HALF_DIV - 1)) && bclk_reg;
   assign link.bit_clock = bclk_reg;

   always_ff @(posedge clk) begin
      if (rst) begin
         dout_sync_reg  <= '0;
         fsync_sync_reg <= '0;
      end else begin
         dout_sync_reg  <= {dout_sync_reg[0], link.serial_out_line};
         fsync_sync_reg <= {fsync_sync_reg[0], link.serial_out_frame_sync};
      end
   end

   // Host transmits on rising edges, one-cycle sync ahead
   word_shifter shifter (
      .clk       (clk),
      .rst       (rst),
      .fall_edge (fall_edge),
      .rise_edge (rise_edge),
      .rx_line   (dout_sync_reg[1]),
      .rx_sync   (fsync_sync_reg[1]),
      .rx_word   (rx_word),
      .rx_valid  (rx_valid),
      .tx_word   (tx_word),
      .tx_start  (tx_start),
      .tx_busy   (tx_busy),
      .tx_line   (link.serial_in_line),
      .tx_sync   (link.serial_in_frame_sync)
   );

   // ---------------------------------------------
   // Outbound pair: address word then data word
   // ---------------------------------------------
   assign req_ready = !second_reg && !tx_busy;
   assign tx_start  = (req_valid && req_ready) || (second_reg && !tx_busy);
   assign tx_word   = second_reg ? data_hold_reg
                     : {req_read, 10'h000, req_addr};

   always_ff @(posedge clk) begin
      if (rst) begin
         second_reg    <= 1'b0;
         data_hold_reg <= '0;
      end else if (req_valid && req_ready) begin
         second_reg    <= 1'b1;
         data_hold_reg <= req_data;
      end else if (second_reg && !tx_busy) begin
         second_reg <= 1'b0;
      end
   end

   // ---------------------------------------------
   // Inbound pairs from the device
   // ---------------------------------------------
   always_ff @(posedge clk) begin
      rsp_valid <= 1'b0;
      if (rst) begin
         got_addr_reg <= 1'b0;
         rsp_addr     <= '0;
         rsp_data     <= '0;
      end else if (rx_valid) begin
         got_addr_reg <= !got_addr_reg;
         if (!got_addr_reg) begin
            rsp_addr <= rx_word[ADDR_W-1:0];
         end else begin
            rsp_data  <= rx_word;
            rsp_valid <= 1'b1;
         end
      end
   end
endmodule : dsp_host

// [link_if.sv]
// Wires of the host serial link between host and device
`timescale 1ns/10ps
interface link_if;
   logic bit_clock;
   logic serial_in_line;
   logic serial_in_frame_sync;
   logic serial_out_line;
   logic serial_out_frame_sync;
   modport device (
      input  bit_clock,
      input  serial_in_line,
      input  serial_in_frame_sync,
      output serial_out_line,
      output serial_out_frame_sync
   );
   modport host (
      output bit_clock,
      output serial_in_line,
      output serial_in_frame_sync,
      input  serial_out_line,
      input  serial_out_frame_sync
   );
endinterface : link_if

// [link_pkg.sv]
// Constants, register map and word layout of the host serial link
package link_pkg;
   localparam int WORD_W = 16;
   localparam int ADDR_W = 5;
   localparam int RW_BIT = 15;
   localparam logic [4:0] RATE_SYNC_SELECT_ADDR        = 5'h00;
   localparam logic [4:0] BYPASS_POWERDOWN_CONFIG_ADDR = 5'h01;
   localparam logic [4:0] RECEIVE_BIT_BAUD_SELECT_ADDR = 5'h02;
   localparam logic [4:0] TRANSMIT_BIT_BAUD_SELECT_ADDR = 5'h03;
   localparam logic [4:0] RECEIVE_PHASE_SHIFT_ADDR     = 5'h04;
   localparam logic [4:0] TRANSMIT_PHASE_SHIFT_ADDR    = 5'h05;
   localparam logic [4:0] CONVERTER_OUT_SAMPLE_ADDR    = 5'h06;
   localparam logic [4:0] RESAMPLER_IN_SAMPLE_ADDR     = 5'h07;
   localparam logic [4:0] ADC_RESULT_SAMPLE_ADDR       = 5'h08;
   localparam logic [4:0] RESAMPLER_OUT_SAMPLE_ADDR    = 5'h09;
   localparam int NUM_CTRL = 6;
   localparam logic [15:0] CTRL_RESET = 16'h0000;
   localparam logic [15:0] SAMPLE_RESET = 16'h0000;
   // Host link clock divider: half period in clk cycles
   localparam int LINK_HALF_DIV = 4;
endpackage : link_pkg

// [link_props.sv]
// Checker: timing and framing of the serial link wires
`timescale 1ns/10ps
module link_props (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Link wires
   input wire logic bit_clock,
   input wire logic serial_in_line,
   input wire logic serial_in_frame_sync,
   input wire logic serial_out_line,
   input wire logic serial_out_frame_sync
);
   logic [7:0] out_gap_reg;
   logic [7:0] in_gap_reg;

   default clocking dc @(posedge clk);
   endclocking
   default disable iff (rst);

   // ----------------------------------------
   // Gap counters, saturate so idle never wraps
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (rst)
         out_gap_reg <= 8'hFF;
      else if ($fell(serial_out_frame_sync))
         out_gap_reg <= 8'h00;
      else if (out_gap_reg != 8'hFF)
         out_gap_reg <= out_gap_reg + 8'h01;
   end

   always_ff @(posedge clk) begin
      if (rst)
         in_gap_reg <= 8'hFF;
      else if ($fell(serial_in_frame_sync))
         in_gap_reg <= 8'h00;
      else if (in_gap_reg != 8'hFF)
         in_gap_reg <= in_gap_reg + 8'h01;
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   chk_out_sync_width: assert property (
      $rose(serial_out_frame_sync) |=>
      serial_out_frame_sync [*7] ##1 !serial_out_frame_sync)
      else $error("output sync not one bit period wide");
   // Sync of the next word may come in the LSB period, not earlier
   chk_out_spacing: assert property (
      $rose(serial_out_frame_sync) |-> out_gap_reg >= 8'h77)
      else $error("output word shorter than sixteen bits");
   // Edge detect lags the link clock by a few clk cycles
   chk_out_data_edge: assert property (
      $changed(serial_out_line) || $changed(serial_out_frame_sync)
      |-> $past(bit_clock, 2))
      else $error("device output changed away from rising edge");
   chk_in_sync_width: assert property (
      $rose(serial_in_frame_sync) |=>
      serial_in_frame_sync [*7] ##1 !serial_in_frame_sync)
      else $error("input sync not one bit period wide");
   chk_in_sync_edge: assert property (
      $rose(serial_in_frame_sync) |-> bit_clock)
      else $error("input sync rose while link clock low");
   chk_in_spacing: assert property (
      $rose(serial_in_frame_sync) |-> in_gap_reg >= 8'h77)
      else $error("input word shorter than sixteen bits");
   chk_in_data_edge: assert property (
      $changed(serial_in_line) |-> bit_clock)
      else $error("host data changed while link clock low");
   chk_link_clk_half: assert property (
      $rose(bit_clock) |=> bit_clock [*3] ##1 !bit_clock)
      else $error("link clock high phase wrong length");

   cover property ($rose(serial_out_frame_sync));
   cover property ($rose(serial_in_frame_sync));
   cover property (serial_in_frame_sync && serial_out_frame_sync);
endmodule : link_props

// [test_modem_afe_serial_register_port.sv]
// Testbench: host and device ends joined across the serial link
`timescale 1ns/10ps
module test_modem_afe_serial_register_port import link_pkg::*; ;
   logic              clk, rst, req_valid, req_read, req_ready, rsp_valid;
   logic [ADDR_W-1:0] req_addr, rsp_addr;
   logic [WORD_W-1:0] req_data, rsp_data, adc_val, rsm_val, wsh;
   logic [WORD_W-1:0] conv_out, rsm_in, conv_feed, rsm_feed;
   logic [WORD_W-1:0] ctrl [NUM_CTRL];
   logic [WORD_W-1:0] wire_q [$];
   logic [3:0]        ev;
   int                bits_left, err_count, checks_done;

   link_if lnk ();
   afe_device afe_device_i (
      .clk(clk), .rst(rst), .link(lnk.device),
      .adc_result_sample(adc_val), .adc_result_load(ev[0]),
      .resampler_out_sample(rsm_val), .resampler_out_load(ev[1]),
      .converter_out_sample(conv_out), .resampler_in_sample(rsm_in),
      .converter_consume(ev[2]), .resampler_consume(ev[3]),
      .converter_feed(conv_feed), .resampler_feed(rsm_feed),
      .ctrl_out(ctrl));
   dsp_host dsp_host_i (
      .clk(clk), .rst(rst), .link(lnk.host),
      .req_valid(req_valid), .req_read(req_read), .req_addr(req_addr),
      .req_data(req_data), .req_ready(req_ready), .rsp_addr(rsp_addr),
      .rsp_data(rsp_data), .rsp_valid(rsp_valid));
   link_props link_props_i (
      .clk(clk), .rst(rst), .bit_clock(lnk.bit_clock),
      .serial_in_line(lnk.serial_in_line),
      .serial_in_frame_sync(lnk.serial_in_frame_sync),
      .serial_out_line(lnk.serial_out_line),
      .serial_out_frame_sync(lnk.serial_out_frame_sync));

   always #12.5 clk = ~clk;

   // ----------------------------------------
   // Wire monitor: next sync may share the LSB period
   // ----------------------------------------
   always @(negedge lnk.bit_clock) begin
      if (bits_left > 0) begin
         wsh = {wsh[14:0], lnk.serial_out_line};
         bits_left--;
         if (bits_left == 0) wire_q.push_back(wsh);
      end
      if (bits_left == 0 && lnk.serial_out_frame_sync === 1'b1)
         bits_left = 16;
   end

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic cmp(input logic [15:0] got, exp, input string what);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : cmp

   task automatic end_sim;
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : end_sim

   task automatic send(input logic rd, input logic [4:0] a,
                       input logic [15:0] d);
      int n;
      n = 0;
      @(posedge clk);
      req_valid <= 1'b1;
      req_read  <= rd;
      req_addr  <= a;
      req_data  <= d;
      @(negedge clk);
      while (req_ready !== 1'b1 && n < 4000) begin
         @(negedge clk);
         n++;
      end
      if (n >= 4000) begin
         err_count++;
         $display("[FAIL] %0t request not taken", $time);
      end
      @(posedge clk);
      req_valid <= 1'b0;
   endtask : send

   // Margin covers the input synchroniser lag
   task automatic idle;
      int n;
      n = 0;
      @(negedge clk);
      while (req_ready !== 1'b1 && n < 4000) begin
         @(negedge clk);
         n++;
      end
      if (n >= 4000) begin
         err_count++;
         $display("[FAIL] %0t host never went idle", $time);
      end
      repeat (16) @(posedge clk);
   endtask : idle

   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      send(1'b0, a, d);
      idle();
   endtask : wr

   task automatic pulse(input logic [3:0] m);
      @(posedge clk);
      ev <= m;
      @(posedge clk);
      ev <= 4'h0;
   endtask : pulse

   task automatic get_pair(input logic [4:0] a, input logic [15:0] d);
      int n;
      n = 0;
      @(negedge clk);
      while (rsp_valid !== 1'b1 && n < 3000) begin
         @(negedge clk);
         n++;
      end
      cmp({10'h000, rsp_valid, rsp_addr}, {10'h001, a},
          "reply addr");
      cmp(rsp_data, d, "reply data");
      cmp(16'(wire_q.size()), 16'h0002, "wire words");
      if (wire_q.size() == 2) begin
         cmp(wire_q.pop_front(), {11'h000, a}, "wire addr");
         cmp(wire_q.pop_front(), d, "wire data");
      end
   endtask : get_pair

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_ctrl_write;
      // Power-down register last, after all others
      for (int i = 2; i < NUM_CTRL + 2; i++)
         wr(5'(i % NUM_CTRL), 16'h1100 + 16'(i % NUM_CTRL));
      for (int i = 0; i < NUM_CTRL; i++)
         cmp(ctrl[i], 16'h1100 + 16'(i), "ctrl write");
      send(1'b0, 5'h02, 16'hBEEF);
      repeat (200) @(posedge clk);
      cmp(ctrl[2], 16'h1102, "partial pair");
      idle();
      cmp(ctrl[2], 16'hBEEF, "full pair");
   endtask : t_ctrl_write

   task automatic t_samples;
      wr(5'h06, 16'hA5C3);
      wr(5'h07, 16'h5A3C);
      cmp(conv_out, 16'hA5C3, "converter in");
      cmp(rsm_in, 16'h5A3C, "resampler in");
      pulse(4'hC);
      wr(5'h06, 16'h0F0F);
      cmp(conv_feed, 16'hA5C3, "converter feed");
      cmp(rsm_feed, 16'h5A3C, "resampler feed");
   endtask : t_samples

   task automatic t_readonly;
      @(posedge clk);
      adc_val <= 16'h8001;
      pulse(4'h1);
      get_pair(5'h08, 16'h8001);
      wr(5'h08, 16'h1234);
      wr(5'h0A, 16'h1234);
      wr(5'h12, 16'h1234);
      wr(5'h1F, 16'h1234);
      cmp(ctrl[2], 16'hBEEF, "alias write");
      cmp(ctrl[0], 16'h1100, "reserved write");
      cmp(conv_out, 16'h0F0F, "reserved write");
      send(1'b1, 5'h08, 16'h0000);
      get_pair(5'h08, 16'h8001);
   endtask : t_readonly

   task automatic t_reads;
      for (int i = 0; i < NUM_CTRL; i++) begin
         send(1'b1, 5'(i), 16'h1234);
         get_pair(5'(i), (i == 2) ? 16'hBEEF : 16'h1100 + 16'(i));
      end
      send(1'b1, 5'h0A, 16'hFFFF);
      get_pair(5'h0A, 16'h0000);
      send(1'b1, 5'h1F, 16'hFFFF);
      get_pair(5'h1F, 16'h0000);
   endtask : t_reads

   task automatic t_busy;
      @(posedge clk);
      adc_val <= 16'h8000;
      rsm_val <= 16'h7FFF;
      pulse(4'h1);
      send(1'b1, 5'h01, 16'h5555);
      get_pair(5'h08, 16'h8000);
      get_pair(5'h01, 16'h1101);
      pulse(4'h3);
      get_pair(5'h08, 16'h8000);
      get_pair(5'h09, 16'h7FFF);
   endtask : t_busy

   initial begin
      clk = 1'b0;
      rst = 1'b1;
      req_valid = 1'b0;
      req_read = 1'b0;
      req_addr = 5'h00;
      req_data = 16'h0000;
      adc_val = 16'h0000;
      rsm_val = 16'h0000;
      ev = 4'h0;
      bits_left = 0;
      err_count = 0;
      checks_done = 0;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      t_ctrl_write();
      t_samples();
      t_readonly();
      t_reads();
      t_busy();
      end_sim();
   end

   initial begin
      repeat (60000) @(posedge clk);
      err_count++;
      $display("[FAIL] %0t watchdog expired", $time);
      end_sim();
   end
endmodule : test_modem_afe_serial_register_port

// [word_shifter.sv]
// Word shifter: framed 16-bit MSB-first receive and transmit
`timescale 1ns/10ps
module word_shifter
   import link_pkg::*;
(
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              rst,
   // Bit clock edge strobes: synchronised link clock (device) or clock divider (host)
   input  wire logic              fall_edge,
   input  wire logic              rise_edge,
   // Receive side, sampled serial inputs
   input  wire logic              rx_line,
   input  wire logic              rx_sync,
   output logic [WORD_W-1:0]      rx_word,
   output logic                   rx_valid,
   // Transmit side
   input  wire logic [WORD_W-1:0] tx_word,
   input  wire logic              tx_start,
   output logic                   tx_busy,
   output logic                   tx_line,
   output logic                   tx_sync
);
   logic [WORD_W-1:0] rx_shift_reg;
   logic [4:0]        rx_count_reg;
   logic [WORD_W-1:0] tx_shift_reg;
   logic [4:0]        tx_count_reg;
   logic              tx_pend_reg;

   // ---------------------------------------------
   // Receive
   // ---------------------------------------------
   always_ff @(posedge clk) begin
      rx_valid <= 1'b0;
      if (rst) begin
         rx_shift_reg <= '0;
         rx_count_reg <= '0;
         rx_word      <= '0;
      end else if (fall_edge) begin
         if (rx_count_reg != 5'h00) begin
            rx_shift_reg <= {rx_shift_reg[WORD_W-2:0], rx_line};
            rx_count_reg <= rx_count_reg - 5'h01;
            if (rx_count_reg == 5'h01) begin
               rx_word  <= {rx_shift_reg[WORD_W-2:0], rx_line};
               rx_valid <= 1'b1;
            end
         end
         // Sync honoured only when idle or on the LSB cycle
         if (rx_sync && rx_count_reg <= 5'h01) begin
            rx_count_reg <= 5'(WORD_W);
         end
      end
   end

   // ---------------------------------------------
   // Transmit
   // ---------------------------------------------
   assign tx_busy = tx_pend_reg || (tx_count_reg != 5'h00) || tx_sync;

   always_ff @(posedge clk) begin
      if (rst) begin
         tx_shift_reg <= '0;
         tx_count_reg <= '0;
         tx_pend_reg  <= 1'b0;
         tx_line      <= 1'b0;
         tx_sync      <= 1'b0;
      end else begin
         if (tx_start && !tx_busy) begin
            tx_shift_reg <= tx_word;
            tx_pend_reg  <= 1'b1;
         end
         if (rise_edge) begin
            if (tx_pend_reg) begin
               tx_sync     <= 1'b1;
               tx_pend_reg <= 1'b0;
            end else if (tx_sync) begin
               tx_sync      <= 1'b0;
               tx_line      <= tx_shift_reg[WORD_W-1];
               tx_shift_reg <= {tx_shift_reg[WORD_W-2:0], 1'b0};
               tx_count_reg <= 5'(WORD_W - 1);
            end else if (tx_count_reg != 5'h00) begin
               tx_line      <= tx_shift_reg[WORD_W-1];
               tx_shift_reg <= {tx_shift_reg[WORD_W-2:0], 1'b0};
               tx_count_reg <= tx_count_reg - 5'h01;
            end else begin
               tx_line <= 1'b0;
            end
         end
      end
   end
endmodule : word_shifter
